// ===== pwmtt_top.sv
// pwmtt_top.sv: period, special event compare and trigger control of a pwm unit
// assumes: time base, cycle, event and enable come from pwm logic on mclk_in
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pwmtt_params.svh"

module pwmtt_top (
  input wire logic mclk_in,                          // module clock, 125 MHz
  input wire logic arst_n_in,                        // async reset, active low
  input wire logic [`PWMTT_ADDR_W-1:0] reg_addr_in,  // register word address
  input wire logic [15:0] reg_wdata_in,              // register write data
  input wire logic reg_wr_in,                        // write strobe
  input wire logic reg_rd_in,                        // read strobe
  output logic [15:0] reg_rdata_out,                 // read data, next cycle
  input wire logic [15:0] time_base_count_in,        // master time base count
  input wire logic cycle_boundary_in,                // pwm cycle boundary pulse
  input wire logic trigger_event_in,                 // raw trigger event pulse
  input wire logic module_enable_in,                 // pwm module enable
  output logic [15:0] master_period_value_out,       // period to the time base
  output logic special_event_out,                    // special event pulse
  output logic trigger_out                           // thinned trigger pulse
);
  import pwmtt_pkg::*;

  logic [15:0] period_r, period_nxt;
  logic [15:0] sevcmp_r, sevcmp_nxt;
  logic [15:0] trgctl_r, trgctl_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic match_r, match_nxt;
  logic sev_r, sev_nxt;
  pwmtt_state_t trig_state;

  // decode of one register word address
  function automatic logic hit(input logic [`PWMTT_ADDR_W-1:0] a,
                               input logic [`PWMTT_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************************
  // register writes
  // ****************************************************
  always_comb begin
    period_nxt = period_r;
    sevcmp_nxt = sevcmp_r;
    trgctl_nxt = trgctl_r;
    if (reg_wr_in && hit(reg_addr_in, `PWMTT_OFS_PERIOD)) begin
      period_nxt = reg_wdata_in;
    end
    if (reg_wr_in && hit(reg_addr_in, `PWMTT_OFS_SEVCMP)) begin
      sevcmp_nxt = reg_wdata_in;
    end
    if (reg_wr_in && hit(reg_addr_in, `PWMTT_OFS_TRGCTL)) begin
      trgctl_nxt = reg_wdata_in & `PWMTT_TRGCTL_MASK;
    end
  end

  // ****************************************************
  // register reads, unmapped reads zero
  // ****************************************************
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd_in) begin
      if (hit(reg_addr_in, `PWMTT_OFS_PERIOD)) begin
        rdata_nxt = period_r;
      end else if (hit(reg_addr_in, `PWMTT_OFS_SEVCMP)) begin
        rdata_nxt = sevcmp_r;
      end else if (hit(reg_addr_in, `PWMTT_OFS_TRGCTL)) begin
        rdata_nxt = trgctl_r & `PWMTT_TRGCTL_MASK;
      end
    end
  end

  // ****************************************************
  // special event compare
  // ****************************************************
  always_comb begin
    match_nxt = (time_base_count_in == sevcmp_r);
    // pulse only on the first clock of a match
    sev_nxt = match_nxt && !match_r;
  end

  // all registers outside the trigger sequencer
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      period_r <= `PWMTT_RST_PERIOD;
      sevcmp_r <= `PWMTT_RST_SEVCMP;
      trgctl_r <= `PWMTT_RST_TRGCTL;
      rdata_r <= 16'h0000;
      match_r <= 1'b0;
      sev_r <= 1'b0;
    end else begin
      period_r <= period_nxt;
      sevcmp_r <= sevcmp_nxt;
      trgctl_r <= trgctl_nxt;
      rdata_r <= rdata_nxt;
      match_r <= match_nxt;
      sev_r <= sev_nxt;
    end
  end

  // ****************************************************
  // trigger postscaler and start delay
  // ****************************************************
  pwmtt_trig u_trig (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .enable_in(module_enable_in),
    .cycle_in(cycle_boundary_in),
    .event_in(trigger_event_in),
    .div_in(trgctl_r[`PWMTT_DIV_HI:`PWMTT_DIV_LO]),
    .dly_in(trgctl_r[`PWMTT_DLY_HI:`PWMTT_DLY_LO]),
    .state_out(trig_state),
    .trig_out(trigger_out)
  );

  // outputs straight from flip-flops
  assign reg_rdata_out = rdata_r;
  assign master_period_value_out = period_r;
  assign special_event_out = sev_r;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_write(logic [`PWMTT_ADDR_W-1:0] ofs);
    reg_wr_in && reg_addr_in == ofs;
  endsequence

  sequence s_read(logic [`PWMTT_ADDR_W-1:0] ofs);
    reg_rd_in && reg_addr_in == ofs;
  endsequence

  AST_PERIOD_WRITE: assert property (s_write(`PWMTT_OFS_PERIOD) |=>
      master_period_value_out == $past(reg_wdata_in))
    else $error("period write not applied");
  AST_SEVCMP_ROUNDTRIP: assert property (s_write(`PWMTT_OFS_SEVCMP) ##1
      s_read(`PWMTT_OFS_SEVCMP) |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("compare value did not read back");
  AST_RSV_ZERO: assert property (s_read(`PWMTT_OFS_TRGCTL) |=>
      reg_rdata_out[`PWMTT_RSV_HI:`PWMTT_RSV_LO] == 6'h00)
    else $error("reserved trigger bits read nonzero");
  AST_SEV_FIRE: assert property ((time_base_count_in == sevcmp_r) && !match_r
      |=> special_event_out)
    else $error("special event missed");
  AST_SEV_ONE_CLK: assert property (special_event_out |=> !special_event_out)
    else $error("special event longer than one clock");
  AST_SEV_CAUSE: assert property (special_event_out |->
      $past(time_base_count_in) == $past(sevcmp_r))
    else $error("special event without a match");

  // ****************************************************
  // register hold, write and read checks
  // ****************************************************
  // compare register takes the written word
  AST_SEVCMP_WRITE: assert property (s_write(`PWMTT_OFS_SEVCMP) |=>
      sevcmp_r == $past(reg_wdata_in))
    else $error("compare write not applied");

  // trigger control keeps only its implemented fields
  AST_TRGCTL_WRITE: assert property (s_write(`PWMTT_OFS_TRGCTL) |=>
      trgctl_r == ($past(reg_wdata_in) & `PWMTT_TRGCTL_MASK))
    else $error("trigger control write not applied");

  // reserved bits never hold a one
  AST_RSV_STORED_ZERO: assert property
      (trgctl_r[`PWMTT_RSV_HI:`PWMTT_RSV_LO] == 6'h00)
    else $error("reserved trigger bits stored nonzero");

  // period holds without a write to it
  AST_PERIOD_HOLD: assert property
      (!(reg_wr_in && reg_addr_in == `PWMTT_OFS_PERIOD) |=> $stable(period_r))
    else $error("period changed without a write");

  // compare value holds without a write to it
  AST_SEVCMP_HOLD: assert property
      (!(reg_wr_in && reg_addr_in == `PWMTT_OFS_SEVCMP) |=> $stable(sevcmp_r))
    else $error("compare value changed without a write");

  // period read returns the stored word
  AST_PERIOD_READ: assert property (s_read(`PWMTT_OFS_PERIOD) |=>
      reg_rdata_out == $past(period_r))
    else $error("period read wrong");

  // compare read returns the stored word
  AST_SEVCMP_READ: assert property (s_read(`PWMTT_OFS_SEVCMP) |=>
      reg_rdata_out == $past(sevcmp_r))
    else $error("compare read wrong");

  // ****************************************************
  // trigger sequencer checks
  // ****************************************************
  sequence s_idle_enabled;
    trig_state == PWMTT_IDLE && module_enable_in;
  endsequence

  sequence s_running;
    trig_state == PWMTT_RUN && module_enable_in;
  endsequence

  // a dropped enable always parks the sequencer
  AST_TRG_IDLE_OFF: assert property
      (!module_enable_in |=> trig_state == PWMTT_IDLE)
    else $error("sequencer not idle after disable");

  // nonzero start delay first counts pwm cycles
  AST_DELAY_ENTRY: assert property
      (s_idle_enabled ##0 trgctl_r[`PWMTT_DLY_HI:`PWMTT_DLY_LO] != 6'h00
      |=> trig_state == PWMTT_DELAY)
    else $error("start delay not entered");

  // triggers only leave the running state
  AST_TRG_RUN_ONLY: assert property
      (trigger_out |-> $past(trig_state) == PWMTT_RUN)
    else $error("trigger outside the running state");

  // running state holds while enabled
  AST_RUN_HOLD: assert property (s_running |=> trig_state == PWMTT_RUN)
    else $error("postscaler left the running state");

endmodule : pwmtt_top
`default_nettype wire

// ===== pwmtt_params.svh
// pwmtt_params.svh: offsets, field positions, reset values and widths
// assumes: included by bare name from the design files of the block
`ifndef PWMTT_PARAMS_SVH
`define PWMTT_PARAMS_SVH

// ****************************************************
// register map, word offsets on the register port
// ****************************************************
`define PWMTT_ADDR_W 4
`define PWMTT_OFS_PERIOD 4'h0
`define PWMTT_OFS_SEVCMP 4'h1
`define PWMTT_OFS_TRGCTL 4'h2

// ****************************************************
// reset values
// ****************************************************
`define PWMTT_RST_PERIOD 16'hFFF8
`define PWMTT_RST_SEVCMP 16'h0000
`define PWMTT_RST_TRGCTL 16'h0000

// ****************************************************
// trigger control word fields
// ****************************************************
`define PWMTT_DIV_HI 15
`define PWMTT_DIV_LO 12
`define PWMTT_RSV_HI 11
`define PWMTT_RSV_LO 6
`define PWMTT_DLY_HI 5
`define PWMTT_DLY_LO 0
`define PWMTT_TRGCTL_MASK 16'hF03F

`endif

// ===== pwmtt_pkg.sv
// pwmtt_pkg.sv: types shared by the trigger timing block
// assumes: compiled before the design modules
package pwmtt_pkg;

  // ****************************************************
  // start-delay sequencer states, one-hot
  // ****************************************************
  typedef enum logic [2:0] {
    PWMTT_IDLE  = 3'b001,
    PWMTT_DELAY = 3'b010,
    PWMTT_RUN   = 3'b100
  } pwmtt_state_t;

endpackage : pwmtt_pkg

// ===== pwmtt_trig.sv
// pwmtt_trig.sv: start delay and trigger postscaler of one generator
// assumes: all inputs come from logic on mclk_in, events are one-clock pulses
`timescale 1ns/100ps
`default_nettype none
`include "pwmtt_params.svh"

module pwmtt_trig (
  input wire logic mclk_in,                 // module clock
  input wire logic arst_n_in,               // async reset, active low
  input wire logic enable_in,               // pwm module enable level
  input wire logic cycle_in,                // pwm cycle boundary pulse
  input wire logic event_in,                // raw trigger event pulse
  input wire logic [3:0] div_in,            // trigger divide field
  input wire logic [5:0] dly_in,            // trigger start delay field
  output var pwmtt_pkg::pwmtt_state_t state_out, // sequencer state
  output logic trig_out                     // thinned trigger pulse
);
  import pwmtt_pkg::*;

  pwmtt_state_t state_r, state_nxt;
  logic [5:0] cyc_r, cyc_nxt;
  logic [3:0] evt_r, evt_nxt;
  logic trig_r, trig_nxt;

  // ****************************************************
  // next-state logic
  // ****************************************************
  always_comb begin
    state_nxt = state_r;
    cyc_nxt = cyc_r;
    evt_nxt = evt_r;
    trig_nxt = 1'b0;
    case (state_r)
      PWMTT_IDLE: begin
        cyc_nxt = 6'h00;
        evt_nxt = 4'h0;
        if (enable_in) begin
          // zero delay field starts at once
          state_nxt = (dly_in == 6'h00) ? PWMTT_RUN : PWMTT_DELAY;
        end
      end
      PWMTT_DELAY: begin
        // count pwm cycles after enable
        if (cycle_in) begin
          cyc_nxt = cyc_r + 6'h01;
          if (cyc_nxt >= dly_in) begin
            state_nxt = PWMTT_RUN;
          end
        end
      end
      PWMTT_RUN: begin
        // one output per div+1 events
        if (event_in) begin
          if (evt_r >= div_in) begin
            evt_nxt = 4'h0;
            trig_nxt = 1'b1;
          end else begin
            evt_nxt = evt_r + 4'h1;
          end
        end
      end
      default: begin
        state_nxt = PWMTT_IDLE;
      end
    endcase
    // disable wins over every next-state choice
    if (!enable_in) begin
      state_nxt = PWMTT_IDLE;
    end
  end

  // registers only
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= PWMTT_IDLE;
      cyc_r <= 6'h00;
      evt_r <= 4'h0;
      trig_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cyc_r <= cyc_nxt;
      evt_r <= evt_nxt;
      trig_r <= trig_nxt;
    end
  end

  assign state_out = state_r;
  assign trig_out = trig_r;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_last_cycle;
    state_r == PWMTT_DELAY && enable_in && cycle_in && (cyc_r + 6'h01 >= dly_in);
  endsequence

  AST_DELAY_DONE: assert property (s_last_cycle |=> state_r == PWMTT_RUN)
    else $error("start delay did not end on the programmed cycle");
  AST_NO_TRIG_EARLY: assert property (state_r != PWMTT_RUN |=> !trig_r)
    else $error("trigger before start delay elapsed");
  AST_DIV_ZERO: assert property
    (state_r == PWMTT_RUN && enable_in && event_in && div_in == 4'h0 |=> trig_r)
    else $error("divide by one dropped an event");
  AST_TRIG_CAUSE: assert property (trig_r |-> $past(event_in) && $past(evt_r) >= $past(div_in))
    else $error("trigger without the counted event");

endmodule : pwmtt_trig
`default_nettype wire

// ===== pwmtt_top_tb_top.sv
// pwmtt_top_tb_top.sv: self-checking bench for the trigger timing block
// assumes: pwmtt_params.svh, pwmtt_pkg and the design modules are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "pwmtt_params.svh"

module pwmtt_top_tb_top;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic [15:0] time_base_count_in = 16'hFFFF;
  logic cycle_boundary_in = 1'b0;
  logic trigger_event_in = 1'b0;
  logic module_enable_in = 1'b0;
  logic [15:0] master_period_value_out;
  logic special_event_out;
  logic trigger_out;
  logic rd_d = 1'b0;
  logic [15:0] exp_q[$];
  int fails = 0;
  int compares = 0;
  int trig_cnt = 0;
  int sev_cnt = 0;
  logic [15:0] v;
  int t0;

  pwmtt_top dut_u (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .time_base_count_in(time_base_count_in),
    .cycle_boundary_in(cycle_boundary_in), .trigger_event_in(trigger_event_in),
    .module_enable_in(module_enable_in), .master_period_value_out(master_period_value_out),
    .special_event_out(special_event_out), .trigger_out(trigger_out));

  // ****************************************************
  // clock and shared tasks
  // ****************************************************
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // bus steps start just after an edge; a strobe stays up until the next step
  task wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    @(posedge mclk_in);
  endtask : wr

  task rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr_in <= a;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk_in);
  endtask : rd

  // lowers both strobes for one cycle
  task idle;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    @(posedge mclk_in);
  endtask : idle

  // holds the cycle boundary or the trigger event line high for n clocks
  task pulse(input bit ev, input int n);
    repeat (n) begin
      @(posedge mclk_in);
      if (ev) trigger_event_in <= 1'b1;
      else cycle_boundary_in <= 1'b1;
    end
    @(posedge mclk_in);
    trigger_event_in <= 1'b0;
    cycle_boundary_in <= 1'b0;
  endtask : pulse

  task test_done;
    $display("checks %0d, errors %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // monitor: read data in the cycle after the strobe, pulse counts
  always @(posedge mclk_in) begin
    rd_d <= reg_rd_in;
    if (rd_d) chk(reg_rdata_out, exp_q.pop_front());
    if (trigger_out === 1'b1) trig_cnt++;
    if (special_event_out === 1'b1) sev_cnt++;
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    test_done();
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    void'($urandom(32));
    repeat (20) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rd(`PWMTT_OFS_PERIOD, `PWMTT_RST_PERIOD);
    rd(`PWMTT_OFS_SEVCMP, 16'h0000);
    rd(`PWMTT_OFS_TRGCTL, 16'h0000);
    rd(4'hF, 16'h0000);
    v = 16'($urandom());
    wr(`PWMTT_OFS_PERIOD, v);
    rd(`PWMTT_OFS_PERIOD, v);
    chk(master_period_value_out, v);
    wr(4'hF, 16'h1234);
    wr(`PWMTT_OFS_TRGCTL, 16'hFFFF);
    rd(`PWMTT_OFS_TRGCTL, 16'hF03F);
    // special event: held match gives one pulse, a rearmed match another
    v = 16'($urandom()) & 16'h7FFE;
    wr(`PWMTT_OFS_SEVCMP, v);
    rd(`PWMTT_OFS_SEVCMP, v);
    idle();
    time_base_count_in <= v;
    repeat (3) @(posedge mclk_in);
    time_base_count_in <= 16'hFFFF;
    @(posedge mclk_in);
    time_base_count_in <= v;
    @(posedge mclk_in);
    time_base_count_in <= 16'hFFFF;
    repeat (3) @(posedge mclk_in);
    chk(16'(sev_cnt), 16'h0002);
    // postscaler over boundary divides, start delay of two cycles
    for (int k = 0; k < 4; k++) begin
      v = {(k == 0) ? 4'h0 : (k == 1) ? 4'h1 : (k == 2) ? 4'hE : 4'hF, 12'h002};
      wr(`PWMTT_OFS_TRGCTL, v);
      rd(`PWMTT_OFS_TRGCTL, v);
      idle();
      t0 = trig_cnt;
      @(posedge mclk_in);
      module_enable_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      pulse(1'b1, 20);
      pulse(1'b0, 1);
      pulse(1'b1, 20);
      repeat (2) @(posedge mclk_in);
      chk(16'(trig_cnt - t0), 16'h0000);
      pulse(1'b0, 1);
      repeat (2) @(posedge mclk_in);
      pulse(1'b1, 2 * (int'(v[15:12]) + 1));
      repeat (3) @(posedge mclk_in);
      chk(16'(trig_cnt - t0), 16'h0002);
      module_enable_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
    repeat (3) @(posedge mclk_in);
    test_done();
  end
endmodule : pwmtt_top_tb_top

`default_nettype wire
